//--- hwwdt_pkg.sv
/*
 * constants for the hardware watchdog: register addresses, unlock bytes,
 * counter widths and reset pulse timing.
 * assumes an 8-bit special function register bus on the core clock.
 */
package hwwdt_pkg;
  localparam logic [7:0] service_reg_addr = 8'ha6;
  localparam logic [7:0] timeout_select_reg_addr = 8'ha7;
  localparam logic [7:0] unlock_first = 8'h1e;
  localparam logic [7:0] unlock_second = 8'he1;
  localparam int count_width = 14;
  localparam logic [count_width-1:0] count_max = 14'h3fff;
  localparam int prescale_width = 7;
  localparam int select_width = 3;
  localparam logic [select_width-1:0] select_reset = 3'h0;
  localparam int select_lsb = 0;
  localparam int pulse_periods = 96;
  localparam int pulse_width = 7;
  localparam logic [pulse_width-1:0] pulse_last =
    pulse_width'(pulse_periods - 1);
  typedef enum logic [0:0] {hwwdt_wait_first, hwwdt_wait_second}
    hwwdt_unlock_t;
endpackage

//--- hwwdt_sync.sv
/*
 * three-stage input synchroniser; the output follows once stages two
 * and three agree.
 * assumes a single clock with synchronous active-high reset.
 */
`timescale 1ns/10ps
module hwwdt_sync #(
  parameter logic reset_level = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic stage1;
  logic stage2;
  logic stage3;
  wire agree = (stage2 == stage3);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= reset_level;
      stage2 <= reset_level;
      stage3 <= reset_level;
      sync_o <= reset_level;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      if (agree) begin
        sync_o <= stage3;
      end
    end
  end
endmodule

//--- hwwdt_top.sv
/*
 * hardware watchdog: unlock/service sequence, timeout select register,
 * prescaler, 14-bit machine-cycle counter and active-low reset-out pulse.
 * assumes machine_cycle_i is a one-clock strobe from the core clock, and
 * power_down_i is high while the oscillator is stopped.
 */
`timescale 1ns/10ps
module hwwdt_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic machine_cycle_i,
  input wire logic power_down_i,
  input wire logic ext_int_n_i,
  output logic enabled_o,
  output logic rst_out_n_o
);
  hwwdt_pkg::hwwdt_unlock_t unlock_state;
  logic enabled;
  logic [hwwdt_pkg::count_width-1:0] count;
  logic [hwwdt_pkg::prescale_width-1:0] prescale;
  logic [hwwdt_pkg::select_width-1:0] timeout_select;
  logic [hwwdt_pkg::pulse_width-1:0] pulse_count;
  logic pulse_active;
  logic int_hold;
  logic ext_int_n_sync;
  hwwdt_pkg::hwwdt_unlock_t next_unlock_state;
  logic next_enabled;
  logic [hwwdt_pkg::count_width-1:0] next_count;
  logic [hwwdt_pkg::prescale_width-1:0] next_prescale;
  logic next_int_hold;
  logic next_pulse_active;
  logic [hwwdt_pkg::pulse_width-1:0] next_pulse_count;
  logic [7:0] next_rdata;

  hwwdt_sync #(
    .reset_level(1'b1)
  ) u_int_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(ext_int_n_i),
    .sync_o(ext_int_n_sync)
  );

  // decode
  wire service_wr = sfr_wr_i && (sfr_addr_i == hwwdt_pkg::service_reg_addr);
  wire select_wr = sfr_wr_i &&
    (sfr_addr_i == hwwdt_pkg::timeout_select_reg_addr);
  wire select_rd = sfr_rd_i &&
    (sfr_addr_i == hwwdt_pkg::timeout_select_reg_addr);
  wire first_hit = service_wr && (sfr_wdata_i == hwwdt_pkg::unlock_first);
  wire second_hit = service_wr &&
    (sfr_wdata_i == hwwdt_pkg::unlock_second) &&
    (unlock_state == hwwdt_pkg::hwwdt_wait_second);
  wire pair_done = second_hit;

  // prescaler tap: last stage of 2^s machine cycles
  wire [hwwdt_pkg::prescale_width-1:0] prescale_last =
    hwwdt_pkg::prescale_width'((8'h01 << timeout_select) - 8'h01);
  wire run = enabled && machine_cycle_i && !power_down_i && !int_hold;
  wire prescale_wrap = run && (prescale == prescale_last);
  wire overflow = prescale_wrap && (count == hwwdt_pkg::count_max);

  // unlock sequence: next state
  always_comb begin
    next_unlock_state = unlock_state;
    if (pulse_active) begin
      next_unlock_state = hwwdt_pkg::hwwdt_wait_first;
    end else if (service_wr) begin
      case (unlock_state)
        hwwdt_pkg::hwwdt_wait_first: begin
          if (first_hit) begin
            next_unlock_state = hwwdt_pkg::hwwdt_wait_second;
          end else begin
            next_unlock_state = hwwdt_pkg::hwwdt_wait_first;
          end
        end
        hwwdt_pkg::hwwdt_wait_second: begin
          next_unlock_state = hwwdt_pkg::hwwdt_wait_first;
        end
        default: begin
          next_unlock_state = hwwdt_pkg::hwwdt_wait_first;
        end
      endcase
    end
  end

  // unlock sequence: state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_state <= hwwdt_pkg::hwwdt_wait_first;
    end else begin
      unlock_state <= next_unlock_state;
    end
  end

  // enable, prescaler and counter: next values
  always_comb begin
    next_enabled = enabled;
    next_count = count;
    next_prescale = prescale;
    if (overflow || pulse_active) begin
      next_enabled = 1'b0;
      next_count = '0;
      next_prescale = '0;
    end else if (pair_done) begin
      next_enabled = 1'b1;
      next_count = '0;
      next_prescale = '0;
    end else if (run) begin
      if (prescale_wrap) begin
        next_prescale = '0;
        next_count = count + 1'b1;
      end else begin
        next_prescale = prescale + 1'b1;
      end
    end
  end

  // enable, prescaler and counter registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enabled <= 1'b0;
      count <= '0;
      prescale <= '0;
    end else begin
      enabled <= next_enabled;
      count <= next_count;
      prescale <= next_prescale;
    end
  end

  // power-down exit by interrupt: hold until pin high
  always_comb begin
    next_int_hold = int_hold;
    if (power_down_i && !ext_int_n_sync) begin
      next_int_hold = 1'b1;
    end else if (ext_int_n_sync) begin
      next_int_hold = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_hold <= 1'b0;
    end else begin
      int_hold <= next_int_hold;
    end
  end

  // timeout select register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_select <= hwwdt_pkg::select_reset;
    end else if (select_wr) begin
      timeout_select <= sfr_wdata_i[hwwdt_pkg::select_lsb +:
        hwwdt_pkg::select_width];
    end
  end

  // read port: only the select field is visible
  always_comb begin
    if (select_rd) begin
      next_rdata = {5'h00, timeout_select};
    end else begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else begin
      sfr_rdata_o <= next_rdata;
    end
  end

  // reset-out pulse: next values
  always_comb begin
    next_pulse_active = pulse_active;
    next_pulse_count = pulse_count;
    if (overflow) begin
      next_pulse_active = 1'b1;
      next_pulse_count = '0;
    end else if (pulse_active) begin
      if (pulse_count == hwwdt_pkg::pulse_last) begin
        next_pulse_active = 1'b0;
      end
      next_pulse_count = pulse_count + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_active <= 1'b0;
      pulse_count <= '0;
    end else begin
      pulse_active <= next_pulse_active;
      pulse_count <= next_pulse_count;
    end
  end

  assign rst_out_n_o = !pulse_active;
  assign enabled_o = enabled;
endmodule

//--- hwwdt_sva.sv
/* watchdog port checker; bound to hwwdt_top below */
`timescale 1ns/10ps
module hwwdt_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic power_down_i,
  input wire logic enabled_o,
  input wire logic rst_out_n_o
);
  logic [7:0] n;
  wire w6 = sfr_wr_i && sfr_addr_i == 8'ha6;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // low cycles of the pulse so far
  always_ff @(posedge clk_i) n <= rst_out_n_o ? 8'h0 : n + 8'h1;
  chk_reset_off: assert property ($fell(rst_i) |-> !enabled_o)
    else $error("on after reset");
  chk_enable_pair: assert property (w6 && sfr_wdata_i == 8'h1e ##1
    !sfr_wr_i ##1 w6 && sfr_wdata_i == 8'he1 && rst_out_n_o |=> enabled_o)
    else $error("pair ignored");
  chk_stays_on: assert property (enabled_o && rst_out_n_o |=>
    enabled_o || !rst_out_n_o) else $error("turned off");
  chk_pulse_off: assert property (!rst_out_n_o |-> !enabled_o)
    else $error("on in pulse");
  chk_pulse_len: assert property ($rose(rst_out_n_o) |-> n == 8'h60)
    else $error("pulse not 96");
  chk_pulse_max: assert property (!rst_out_n_o |-> n < 8'h60)
    else $error("pulse long");
  chk_pd_hold: assert property (power_down_i && rst_out_n_o |=>
    rst_out_n_o) else $error("overflow in power-down");
  chk_rd_select: assert property (sfr_rd_i && sfr_addr_i == 8'ha7 |=>
    sfr_rdata_o[7:3] == 5'h0) else $error("upper bits set");
endmodule
bind hwwdt_top hwwdt_sva hwwdt_sva_i (.clk_i, .rst_i, .sfr_addr_i,
  .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .power_down_i,
  .enabled_o, .rst_out_n_o);

//--- hwwdt_cpu.sv
/* cpu model on the register bus; bench calls its tasks */
`timescale 1ns/10ps
module hwwdt_cpu (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  initial {addr_o, wr_o, rd_o, wdata_o} = 18'h0;
  task automatic acc(input logic [7:0] a, d, input logic w);
    @(posedge clk_i) #1;
    addr_o = a;
    wdata_o = a == 8'ha7 ? d & 8'h07 : d;
    {wr_o, rd_o} = {w, !w};
    @(posedge clk_i) #1;
    {wr_o, rd_o} = 2'h0;
    {addr_o, wdata_o} = ~{addr_o, wdata_o};
  endtask
  task automatic svc();
    acc(8'ha6, 8'h1e, 1'b1);
    acc(8'ha6, 8'he1, 1'b1);
  endtask
endmodule

//--- hwwdt_top_tb.sv
/* self-checking bench; cpu model drives the register bus */
`timescale 1ns/10ps
module hwwdt_top_tb;
  logic clk_i = 0, rst_i = 1, mc = 0, pd = 0, int_n = 1, rd_seen = 0;
  logic [7:0] addr, wd, rdata, q[$];
  logic wr, rd, en, rst_n;
  int errors = 0, checks = 0, seed = 42, n;
  always #12.5 clk_i = ~clk_i;
  hwwdt_cpu hwwdt_cpu_i (.clk_i, .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wd));
  hwwdt_top hwwdt_top_i (.clk_i, .rst_i, .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdata),
    .machine_cycle_i(mc), .power_down_i(pd), .ext_int_n_i(int_n),
    .enabled_o(en), .rst_out_n_o(rst_n));
  task automatic chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %0t got %0h want %0h", $time, s, e);
    end
  endtask
  task automatic rdx(input logic [7:0] a, e);
    q.push_back(e);
    hwwdt_cpu_i.acc(a, 8'h0, 1'b0);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(negedge clk_i) begin
    if (rd_seen) chk(rdata, q.pop_front());
    rd_seen = rd;
  end
  initial begin
    #2250000 errors++;
    results;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    #1 {rst_i, mc} = 2'h1;
    repeat (20) @(posedge clk_i);
    chk(en, 1'b0);
    hwwdt_cpu_i.acc(8'ha6, 8'h1e, 1'b1);
    hwwdt_cpu_i.acc(8'ha6, 8'h55, 1'b1);
    hwwdt_cpu_i.acc(8'ha6, 8'he1, 1'b1);
    chk(en, 1'b0);
    for (int k = 0; k < 8; k++) begin
      hwwdt_cpu_i.acc(8'ha7, {5'($random(seed)), 3'(k)}, 1'b1);
      rdx(8'ha7, 8'(k));
    end
    rdx(8'ha6, 8'h0);
    rdx(8'h55, 8'h0);
    for (int s = 0; s < 2; s++) begin
      hwwdt_cpu_i.acc(8'ha7, 8'(s), 1'b1);
      hwwdt_cpu_i.svc();
      chk(en, 1'b1);
      pd = (s == 0);
      repeat (10000) @(posedge clk_i) #1 {mc, int_n} = 2'($random(seed));
      {pd, int_n, mc} = 3'h3;
      repeat (8) @(posedge clk_i);
      hwwdt_cpu_i.svc();
      n = 0;
      while (rst_n === 1'b1 && n < 70000) begin
        @(posedge clk_i) #1;
        n++;
      end
      chk(n, 16384 << s);
      #2500 chk(en, 1'b0);
    end
    results;
  end
endmodule
